//--- rtl/sensor_status_event_registers.sv
// status, snapshot status, result and serial number registers
`timescale 1ns/100ps

module sensor_status_event_registers
	import sensor_status_pkg::*;
(
	// core clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial link side, on the link clock
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic acc_valid,
	input wire reg_access_t acc_in,
	output logic acc_ready,
	output logic acc_done,
	output logic [DATA_W-1:0] acc_rdata,
	// measurement datapath, on mclk
	input wire logic temp_load,
	input wire logic [DATA_W-1:0] temp_value,
	input wire logic press_load,
	input wire logic [DATA_W-1:0] press_value,
	input wire logic chip_idle,
	input wire logic dsp_saturated,
	input wire logic bridge_supply_failure,
	input wire logic bridge_check_failure,
	input wire logic crc_error,
	input wire logic [2*DATA_W-1:0] serial_number
);

	////////////////////////////////////////////////////////////////////////
	// link domain: hold one access, toggle a request, wait for the ack

	link_state_t link_state_reg, link_state_next;
	reg_access_t hold_reg, hold_next;
	logic req_tgl_reg, req_tgl_next;
	logic [DATA_W-1:0] rdata_out_reg, rdata_out_next;
	logic done_reg, done_next;
	logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
	logic [DATA_W-1:0] rdata_reg, rdata_next;

	// ack edge read between the second and third stages
	logic ack_seen;
	assign ack_seen = ack_s2_reg ^ ack_s3_reg;
	assign acc_ready = (link_state_reg == LINK_IDLE);
	assign acc_done = done_reg;
	assign acc_rdata = rdata_out_reg;

	always_comb begin
		link_state_next = link_state_reg;
		hold_next = hold_reg;
		req_tgl_next = req_tgl_reg;
		rdata_out_next = rdata_out_reg;
		done_next = 1'b0;
		case (link_state_reg)
			LINK_IDLE: begin
				if (acc_valid) begin
					hold_next = acc_in;
					req_tgl_next = ~req_tgl_reg;
					link_state_next = LINK_WAIT;
				end
			end
			LINK_WAIT: begin
				// rdata_reg is stable once the ack toggles
				if (ack_seen) begin
					rdata_out_next = rdata_reg;
					done_next = 1'b1;
					link_state_next = LINK_IDLE;
				end
			end
			default: begin
				link_state_next = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_state_reg <= LINK_IDLE;
			hold_reg <= '0;
			req_tgl_reg <= 1'b0;
			rdata_out_reg <= DATA_ZERO;
			done_reg <= 1'b0;
		end else begin
			link_state_reg <= link_state_next;
			hold_reg <= hold_next;
			req_tgl_reg <= req_tgl_next;
			rdata_out_reg <= rdata_out_next;
			done_reg <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain: request sync, ack toggle; ack sync back on link_clk

	logic req_s1_reg, req_s2_reg, req_s3_reg;
	logic ack_tgl_reg, ack_tgl_next;
	logic fire;

	assign fire = req_s2_reg ^ req_s3_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register bank

	logic [DATA_W-1:0] ev_reg, ev_next;
	logic snap_s_reg, snap_s_next;
	logic snap_t_reg, snap_t_next;
	logic [DATA_W-1:0] temp_reg, temp_next;
	logic [DATA_W-1:0] press_reg, press_next;
	logic [DATA_W-1:0] live_status, snap_status;
	logic temp_read, press_read, status_write;

	// hold_reg is quiet while a request is in flight
	assign temp_read = fire && !hold_reg.write && hold_reg.addr == ADDR_TEMP;
	assign press_read = fire && !hold_reg.write && hold_reg.addr == ADDR_PRESS;
	// only live status writes matter here; command sits elsewhere
	assign status_write = fire && hold_reg.write
		&& hold_reg.addr == ADDR_STATUS;

	always_comb begin
		live_status = ev_reg & EVENT_MASK;
		live_status[BIT_IDLE] = chip_idle;
		live_status[BIT_SAT] = dsp_saturated;
		snap_status = live_status & MIRROR_MASK;
		snap_status[BIT_S_UP] = snap_s_reg;
		snap_status[BIT_T_UP] = snap_t_reg;
	end

	always_comb begin
		ev_next = ev_reg;
		snap_s_next = snap_s_reg;
		snap_t_next = snap_t_reg;
		temp_next = temp_reg;
		press_next = press_reg;
		ack_tgl_next = ack_tgl_reg ^ fire;
		rdata_next = rdata_reg;
		// clears first so that a same-cycle set wins
		if (status_write) begin
			ev_next = ev_next & ~(hold_reg.wdata & EVENT_MASK);
		end
		if (press_read) begin
			snap_s_next = ev_reg[BIT_S_UP];
			ev_next[BIT_S_UP] = 1'b0;
		end
		if (temp_read) begin
			snap_t_next = ev_reg[BIT_T_UP];
			ev_next[BIT_T_UP] = 1'b0;
		end
		if (press_load) begin
			press_next = press_value;
			ev_next[BIT_S_UP] = 1'b1;
			if (ev_reg[BIT_S_UP] && !press_read) begin
				ev_next[BIT_S_MISS] = 1'b1;
			end
		end
		if (temp_load) begin
			temp_next = temp_value;
			ev_next[BIT_T_UP] = 1'b1;
			if (ev_reg[BIT_T_UP] && !temp_read) begin
				ev_next[BIT_T_MISS] = 1'b1;
			end
		end
		if (bridge_supply_failure) begin
			ev_next[BIT_BRIDGE_SUPPLY_FAILURE] = 1'b1;
		end
		if (bridge_check_failure) begin
			ev_next[BIT_BRIDGE_CHECK_FAILURE] = 1'b1;
		end
		if (crc_error) begin
			ev_next[BIT_CRC_ERR] = 1'b1;
		end
		ev_next = ev_next & EVENT_MASK;
		// per-word read; the framing walks 0x2e, 0x30, 0x32 in a burst
		if (fire && !hold_reg.write) begin
			case (hold_reg.addr)
				ADDR_TEMP: rdata_next = temp_reg;
				ADDR_PRESS: rdata_next = press_reg;
				ADDR_SNAP: rdata_next = snap_status;
				ADDR_STATUS: rdata_next = live_status;
				ADDR_SER_LO: rdata_next = serial_number[DATA_W-1:0];
				ADDR_SER_HI: rdata_next = serial_number[2*DATA_W-1:DATA_W];
				default: rdata_next = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ev_reg <= STATUS_RESET;
			snap_s_reg <= 1'b0;
			snap_t_reg <= 1'b0;
			temp_reg <= DATA_ZERO;
			press_reg <= DATA_ZERO;
			ack_tgl_reg <= 1'b0;
			rdata_reg <= DATA_ZERO;
		end else begin
			ev_reg <= ev_next;
			snap_s_reg <= snap_s_next;
			snap_t_reg <= snap_t_next;
			temp_reg <= temp_next;
			press_reg <= press_next;
			ack_tgl_reg <= ack_tgl_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_temp_fresh;
		temp_load && !temp_read;
	endsequence

	// a load that finds the previous value still unread
	sequence s_temp_again;
		ev_reg[BIT_T_UP] ##0 s_temp_fresh;
	endsequence

	a_snap_mirror_bits: assert property (
		(snap_status & MIRROR_MASK) == (live_status & MIRROR_MASK))
		else $error("snapshot differs from live status");

	a_snap_read_mirror: assert property (
		fire && !hold_reg.write && hold_reg.addr == ADDR_SNAP
		|=> (rdata_reg & MIRROR_MASK) == ($past(live_status) & MIRROR_MASK))
		else $error("snapshot read differs from live status");

	a_snap_copy_flag: assert property (
		temp_read |=> snap_t_reg == $past(ev_reg[BIT_T_UP]))
		else $error("temperature update flag not copied");

	a_press_up_cycle: assert property (
		press_load |=> ev_reg[BIT_S_UP] ##0 press_reg == $past(press_value))
		else $error("pressure load did not update");

	a_temp_up_cycle: assert property (
		temp_load |=> ev_reg[BIT_T_UP] ##0 temp_reg == $past(temp_value))
		else $error("temperature load did not update");

	a_press_missed_set: assert property (
		press_load && !press_read && ev_reg[BIT_S_UP] |=> ev_reg[BIT_S_MISS])
		else $error("missed pressure not flagged");

	a_temp_read_clear: assert property (
		temp_read && !temp_load |=> !ev_reg[BIT_T_UP])
		else $error("temperature read did not clear flag");

	a_temp_missed_set: assert property (
		s_temp_again |=> ev_reg[BIT_T_MISS])
		else $error("missed temperature not flagged");

	a_event_sticky_hold: assert property (
		ev_reg[BIT_BRIDGE_SUPPLY_FAILURE] && !status_write |=> ev_reg[BIT_BRIDGE_SUPPLY_FAILURE])
		else $error("event flag dropped without clear");

	a_clear_all_events: assert property (
		status_write && hold_reg.wdata == ALL_ONES && !temp_load
		&& !press_load && !bridge_supply_failure && !bridge_check_failure
		&& !crc_error |=> (ev_reg & EVENT_MASK) == STATUS_RESET)
		else $error("all-ones write left events set");

	a_cond_follow_hw: assert property (
		live_status[BIT_IDLE] == chip_idle
		&& live_status[BIT_SAT] == dsp_saturated)
		else $error("condition flag not following hardware");

	a_reserved_zero: assert property (
		(live_status & ~(EVENT_MASK | COND_MASK)) == STATUS_RESET)
		else $error("reserved status bit set");

	a_write_protect: assert property (
		fire && hold_reg.write && hold_reg.addr == ADDR_TEMP && !temp_load
		|=> $stable(temp_reg))
		else $error("protected register written");

endmodule : sensor_status_event_registers

//--- pkg/sensor_status_pkg.sv
// shared constants and types for the sensor status and event register bank
package sensor_status_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// word addresses on the serial register port
	localparam logic [7:0] ADDR_CMD = 8'h22;
	localparam logic [7:0] ADDR_TEMP = 8'h2e;
	localparam logic [7:0] ADDR_PRESS = 8'h30;
	localparam logic [7:0] ADDR_SNAP = 8'h32;
	localparam logic [7:0] ADDR_STATUS = 8'h36;
	localparam logic [7:0] ADDR_SER_LO = 8'h50;
	localparam logic [7:0] ADDR_SER_HI = 8'h52;

	// status bit positions
	localparam int BIT_IDLE = 0;
	localparam int BIT_S_UP = 3;
	localparam int BIT_T_UP = 4;
	localparam int BIT_BRIDGE_SUPPLY_FAILURE = 7;
	localparam int BIT_BRIDGE_CHECK_FAILURE = 8;
	localparam int BIT_SAT = 10;
	localparam int BIT_CRC_ERR = 11;
	localparam int BIT_S_MISS = 14;
	localparam int BIT_T_MISS = 15;

	// event bits that write-one clears; bits 0 and 10 are conditions
	localparam logic [15:0] EVENT_MASK = 16'hc998;
	localparam logic [15:0] COND_MASK = 16'h0401;
	// bits copied straight from live status into the snapshot
	localparam logic [15:0] MIRROR_MASK = 16'hffe1;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] ALL_ONES = 16'hffff;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	// one register access from the serial framing logic
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_access_t;

	// link-side access sequencer, one-hot
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b01,
		LINK_WAIT = 2'b10
	} link_state_t;

endpackage : sensor_status_pkg

//--- verif/status_host.sv
// host model issuing single register accesses on the link port
`timescale 1ns/100ps
module status_host
	import sensor_status_pkg::*;
(
	// link clock
	input wire logic link_clk,
	// access port
	output logic acc_valid,
	output reg_access_t acc_in,
	input wire logic acc_ready,
	input wire logic acc_done,
	input wire logic [DATA_W-1:0] acc_rdata
);
	initial begin
		acc_valid = 1'b0;
		acc_in = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one access at a time; burst is three of these in address order
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
		int n;
		rd = 'x;
		@(negedge link_clk);
		acc_in = '{write: wr, addr: a, wdata: wd};
		acc_valid = 1'b1;
		// ready and done move on the rising edge; look between edges
		while (acc_ready !== 1'b1) @(negedge link_clk);
		@(posedge link_clk);
		@(negedge link_clk);
		acc_valid = 1'b0;
		// released bus shows a different pattern, not the last value
		acc_in = ~acc_in;
		for (n = 0; n < 20; n++) begin
			if (acc_done === 1'b1) begin
				rd = acc_rdata;
				break;
			end
			@(negedge link_clk);
		end
	endtask : access
endmodule : status_host

//--- verif/sensor_status_event_registers_tb.sv
// self-checking bench for the status and event register bank
`timescale 1ns/100ps
module sensor_status_event_registers_tb;
	import sensor_status_pkg::*;
	logic mclk, rst_n, link_clk, link_rst_n, acc_valid, acc_ready, acc_done;
	reg_access_t acc_in;
	logic [DATA_W-1:0] acc_rdata, t_val, s_val;
	logic t_ld, s_ld, idle, sat, bs, bc, crc;
	int num_errors, comparisons;
	// arbitrary serial value
	localparam logic [31:0] SER = 32'h5a3c_96e1;
	localparam logic [15:0] C = 16'h0401;

	sensor_status_event_registers i_dut(.mclk(mclk), .rst_n(rst_n),
		.link_clk(link_clk), .link_rst_n(link_rst_n), .acc_valid(acc_valid),
		.acc_in(acc_in), .acc_ready(acc_ready), .acc_done(acc_done),
		.acc_rdata(acc_rdata), .temp_load(t_ld), .temp_value(t_val),
		.press_load(s_ld), .press_value(s_val), .chip_idle(idle),
		.dsp_saturated(sat), .bridge_supply_failure(bs),
		.bridge_check_failure(bc), .crc_error(crc), .serial_number(SER));
	status_host i_host(.link_clk(link_clk), .acc_valid(acc_valid),
		.acc_in(acc_in), .acc_ready(acc_ready), .acc_done(acc_done),
		.acc_rdata(acc_rdata));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// link clock unrelated in phase to mclk
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #15 link_clk = ~link_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_host.access(1'b0, a, DATA_ZERO, d);
		comparisons++;
		if (d !== e) begin
			num_errors++;
			$display("mismatch %0t addr %h got %h exp %h", $time, a, d, e);
		end
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		logic [15:0] d;
		i_host.access(1'b1, a, v, d);
		comparisons++;
		if ($isunknown(d)) begin
			num_errors++;
			$display("mismatch %0t addr %h write never finished", $time, a);
		end
	endtask : wr

	// one-cycle result load on mclk
	task automatic load(input logic p, input logic [15:0] v);
		@(negedge mclk);
		if (p) begin
			s_val = v;
			s_ld = 1'b1;
		end else begin
			t_val = v;
			t_ld = 1'b1;
		end
		@(negedge mclk);
		s_ld = 1'b0;
		t_ld = 1'b0;
	endtask : load

	////////////////////////////////////////////////////////////////////////
	initial begin
		{t_ld, s_ld, idle, sat, bs, bc, crc} = '0;
		t_val = '0;
		s_val = '0;
		num_errors = 0;
		comparisons = 0;
		rst_n = 1'b0;
		link_rst_n = 1'b0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		// link flops need a rising link edge inside reset to leave unknown
		repeat (2) @(negedge link_clk);
		link_rst_n = 1'b1;
		rd(ADDR_STATUS, STATUS_RESET);
		rd(ADDR_SNAP, STATUS_RESET);
		@(negedge mclk);
		idle = 1'b1;
		sat = 1'b1;
		wr(ADDR_STATUS, ALL_ONES);
		rd(ADDR_STATUS, C);
		load(1'b0, 16'h1234);
		load(1'b0, 16'h2345);
		load(1'b1, 16'h4321);
		load(1'b1, 16'h5678);
		rd(ADDR_STATUS, 16'hc018 | C);
		rd(ADDR_TEMP, 16'h2345);
		rd(ADDR_PRESS, 16'h5678);
		rd(ADDR_SNAP, 16'hc018 | C);
		rd(ADDR_STATUS, 16'hc000 | C);
		rd(ADDR_TEMP, 16'h2345);
		rd(ADDR_PRESS, 16'h5678);
		rd(ADDR_SNAP, 16'hc000 | C);
		@(negedge mclk);
		{bs, bc, crc} = 3'b111;
		@(negedge mclk);
		{bs, bc, crc} = 3'b000;
		rd(ADDR_STATUS, 16'hc980 | C);
		wr(ADDR_SNAP, ALL_ONES);
		wr(ADDR_STATUS, 16'h32e6);
		rd(ADDR_STATUS, 16'hc900 | C);
		wr(ADDR_TEMP, 16'hbeef);
		rd(ADDR_TEMP, 16'h2345);
		wr(ADDR_STATUS, ALL_ONES);
		@(negedge mclk);
		idle = 1'b0;
		rd(ADDR_STATUS, 16'h0400);
		rd(ADDR_SER_LO, SER[15:0]);
		rd(ADDR_SER_HI, SER[31:16]);
		rd(8'h40, DATA_ZERO);
		conclude();
	end

	// watchdog well beyond the few tens of accesses above
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
endmodule : sensor_status_event_registers_tb
